// ==== mmvd_decode.sv ====
`timescale 1ns/1ps
module mmvd_decode #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter logic [15:0] LS_BASE = mmvd_pkg::LS_RAM_BASE_DEF
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic reset_pin_n,
   // Program flow requests
   input wire logic irq_req,
   input wire logic [3:0] irq_src,
   input wire logic one_byte_table_call,
   input wire logic [4:0] table_index,
   input wire logic branch_req,
   input wire logic [15:0] branch_addr,
   input wire logic fetch_req,
   // Program memory
   output logic [15:0] rom_addr,
   input wire logic [7:0] rom_rdata,
   // Program counter and fetch result
   output logic [15:0] program_counter,
   output logic pc_valid,
   output logic busy,
   output logic [7:0] fetch_byte,
   output logic fetch_valid,
   output logic fetch_fault,
   // Data address decode
   input wire logic data_req,
   input wire logic [15:0] data_addr,
   input wire logic data_stack,
   output logic dec_valid,
   output logic [2:0] dec_region,
   output logic [15:0] dec_offset,
   output logic dec_short_area,
   output logic dec_stack_fault
);
   localparam int unsigned ROM_SIZE = LARGE_VARIANT ? mmvd_pkg::ROM_LARGE : mmvd_pkg::ROM_SMALL;
   localparam int unsigned HS_SIZE = LARGE_VARIANT ? mmvd_pkg::HS_LARGE : mmvd_pkg::HS_SMALL;
   localparam int unsigned LS_SIZE = LARGE_VARIANT ? mmvd_pkg::LS_LARGE : mmvd_pkg::LS_SMALL;

   // Areas must not overlap
   if (32'(LS_BASE) < ROM_SIZE || 32'(LS_BASE) + LS_SIZE > 32'(mmvd_pkg::HS_RAM_LAST) + 32'd1 - HS_SIZE) begin
      $error("low-speed RAM base overlaps ROM or high-speed RAM");
   end

   mmvd_dec_if dif ();

   mmvd_region_dec #(
      .ROM_SIZE(ROM_SIZE),
      .HS_SIZE(HS_SIZE),
      .LS_SIZE(LS_SIZE),
      .LS_BASE(LS_BASE)
   ) u_dec (
      .d(dif.dec)
   );

   assign dif.addr = data_addr;
   assign dif.stack_acc = data_stack;

   // Either reset source holds the block
   logic in_reset;
   assign in_reset = srst || !reset_pin_n;

   mmvd_pkg::mmvd_state_e state_r, state_nxt;
   logic [15:0] tbl_r, tbl_nxt;
   logic [7:0] lo_r, lo_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [15:0] rom_addr_r, rom_addr_nxt;
   logic [1:0] fpipe_r, fpipe_nxt;
   logic [1:0] ffault_r, ffault_nxt;
   logic pc_valid_r, pc_valid_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] fetch_byte_r, fetch_byte_nxt;
   logic fetch_valid_r, fetch_valid_nxt;
   logic fetch_fault_r, fetch_fault_nxt;

   always_comb begin
      state_nxt = state_r;
      tbl_nxt = tbl_r;
      lo_nxt = lo_r;
      pc_nxt = pc_r;
      rom_addr_nxt = rom_addr_r;
      pc_valid_nxt = pc_valid_r;
      fpipe_nxt = {fpipe_r[0], 1'b0};
      ffault_nxt = {ffault_r[0], 1'b0};
      fetch_valid_nxt = fpipe_r[1];
      fetch_byte_nxt = fpipe_r[1] ? rom_rdata : fetch_byte_r;
      fetch_fault_nxt = fpipe_r[1] && ffault_r[1];
      case (state_r)
         mmvd_pkg::MMVD_ST_WAIT_LO: begin
            rom_addr_nxt = tbl_r + 16'h0001;
            state_nxt = mmvd_pkg::MMVD_ST_WAIT_HI;
         end
         mmvd_pkg::MMVD_ST_WAIT_HI: begin
            lo_nxt = rom_rdata;
            state_nxt = mmvd_pkg::MMVD_ST_CAP_HI;
         end
         mmvd_pkg::MMVD_ST_CAP_HI: begin
            pc_nxt = {rom_rdata, lo_r};
            pc_valid_nxt = 1'b1;
            rom_addr_nxt = {rom_rdata, lo_r};
            state_nxt = mmvd_pkg::MMVD_ST_RUN;
         end
         mmvd_pkg::MMVD_ST_RUN: begin
            // Priority: interrupt, table call, branch, fetch
            if (irq_req && irq_src <= mmvd_pkg::IRQ_LAST) begin
               tbl_nxt = mmvd_pkg::mmvd_vec_addr(irq_src);
               rom_addr_nxt = mmvd_pkg::mmvd_vec_addr(irq_src);
               pc_valid_nxt = 1'b0;
               fpipe_nxt = 2'h0;
               state_nxt = mmvd_pkg::MMVD_ST_WAIT_LO;
            end else if (one_byte_table_call) begin
               tbl_nxt = mmvd_pkg::TBL_CALL_BASE + {10'h000, table_index, 1'b0};
               rom_addr_nxt = mmvd_pkg::TBL_CALL_BASE + {10'h000, table_index, 1'b0};
               pc_valid_nxt = 1'b0;
               fpipe_nxt = 2'h0;
               state_nxt = mmvd_pkg::MMVD_ST_WAIT_LO;
            end else if (branch_req) begin
               pc_nxt = branch_addr;
               rom_addr_nxt = branch_addr;
            end else if (fetch_req) begin
               rom_addr_nxt = pc_r;
               pc_nxt = pc_r + 16'h0001;
               fpipe_nxt = {fpipe_r[0], 1'b1};
               ffault_nxt = {ffault_r[0], 32'(pc_r) >= ROM_SIZE};
            end
         end
         default: begin
            state_nxt = mmvd_pkg::MMVD_ST_WAIT_LO;
         end
      endcase
      busy_nxt = (state_nxt != mmvd_pkg::MMVD_ST_RUN);
   end

   always_ff @(posedge clk_sys) begin
      if (in_reset) begin
         state_r <= mmvd_pkg::MMVD_ST_WAIT_LO;
         tbl_r <= mmvd_pkg::VEC_RESET;
         rom_addr_r <= mmvd_pkg::VEC_RESET;
         lo_r <= 8'h00;
         pc_r <= mmvd_pkg::PC_RST;
         pc_valid_r <= 1'b0;
         busy_r <= 1'b1;
         fpipe_r <= mmvd_pkg::FETCH_PIPE_RST;
         ffault_r <= mmvd_pkg::FETCH_PIPE_RST;
         fetch_byte_r <= 8'h00;
         fetch_valid_r <= 1'b0;
         fetch_fault_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tbl_r <= tbl_nxt;
         rom_addr_r <= rom_addr_nxt;
         lo_r <= lo_nxt;
         pc_r <= pc_nxt;
         pc_valid_r <= pc_valid_nxt;
         busy_r <= busy_nxt;
         fpipe_r <= fpipe_nxt;
         ffault_r <= ffault_nxt;
         fetch_byte_r <= fetch_byte_nxt;
         fetch_valid_r <= fetch_valid_nxt;
         fetch_fault_r <= fetch_fault_nxt;
      end
   end

   // Data decode result, registered one cycle after the request
   logic dec_valid_r, dec_valid_nxt;
   logic [2:0] dec_region_r, dec_region_nxt;
   logic [15:0] dec_offset_r, dec_offset_nxt;
   logic dec_short_r, dec_short_nxt;
   logic dec_sfault_r, dec_sfault_nxt;

   always_comb begin
      dec_valid_nxt = data_req;
      dec_region_nxt = dec_region_r;
      dec_offset_nxt = dec_offset_r;
      dec_short_nxt = dec_short_r;
      dec_sfault_nxt = 1'b0;
      if (data_req) begin
         dec_region_nxt = dif.region;
         dec_offset_nxt = dif.offset;
         dec_short_nxt = dif.short_area;
         dec_sfault_nxt = dif.stack_bad;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (in_reset) begin
         dec_valid_r <= 1'b0;
         dec_region_r <= mmvd_pkg::MMVD_RG_NONE;
         dec_offset_r <= 16'h0000;
         dec_short_r <= 1'b0;
         dec_sfault_r <= 1'b0;
      end else begin
         dec_valid_r <= dec_valid_nxt;
         dec_region_r <= dec_region_nxt;
         dec_offset_r <= dec_offset_nxt;
         dec_short_r <= dec_short_nxt;
         dec_sfault_r <= dec_sfault_nxt;
      end
   end

   assign rom_addr = rom_addr_r;
   assign program_counter = pc_r;
   assign pc_valid = pc_valid_r;
   assign busy = busy_r;
   assign fetch_byte = fetch_byte_r;
   assign fetch_valid = fetch_valid_r;
   assign fetch_fault = fetch_fault_r;
   assign dec_valid = dec_valid_r;
   assign dec_region = dec_region_r;
   assign dec_offset = dec_offset_r;
   assign dec_short_area = dec_short_r;
   assign dec_stack_fault = dec_sfault_r;
endmodule

// ==== mmvd_pkg.sv ====
package mmvd_pkg;

   // Fixed areas of the 64 KB space
   localparam logic [15:0] VEC_BASE = 16'h0000;
   localparam logic [15:0] VEC_LAST = 16'h0019;
   localparam logic [15:0] TBL_CALL_BASE = 16'h0040;
   localparam logic [15:0] TBL_CALL_LAST = 16'h007f;
   localparam logic [15:0] DATA_AREA_BASE = 16'hfe00;
   localparam logic [15:0] SFR_BASE = 16'hff00;
   localparam logic [15:0] HS_RAM_LAST = 16'hfeff;
   localparam logic [15:0] LS_RAM_BASE_DEF = 16'hf800;

   // Memory sizes in bytes per variant
   localparam int unsigned ROM_SMALL = 16384;
   localparam int unsigned ROM_LARGE = 32768;
   localparam int unsigned HS_SMALL = 256;
   localparam int unsigned HS_LARGE = 320;
   localparam int unsigned LS_SMALL = 128;
   localparam int unsigned LS_LARGE = 256;

   // Vector table entries
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_WDT = 16'h0004;
   localparam logic [15:0] VEC_EXT0 = 16'h0006;
   localparam logic [15:0] VEC_EXT1 = 16'h0008;
   localparam logic [15:0] VEC_TMR_A = 16'h000a;
   localparam logic [15:0] VEC_TMR_B = 16'h000c;
   localparam logic [15:0] VEC_TMR_C = 16'h000e;
   localparam logic [15:0] VEC_CAPT = 16'h0010;
   localparam logic [15:0] VEC_KEY = 16'h0012;
   localparam logic [15:0] VEC_SER_RX = 16'h0014;
   localparam logic [15:0] VEC_SER_TX = 16'h0016;

   // Values after reset
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [1:0] FETCH_PIPE_RST = 2'h0;

   typedef enum logic [3:0] {
      MMVD_IRQ_WATCHDOG = 4'h0,
      MMVD_IRQ_EXT_0 = 4'h1,
      MMVD_IRQ_EXT_1 = 4'h2,
      MMVD_IRQ_TIMER_A = 4'h3,
      MMVD_IRQ_TIMER_B = 4'h4,
      MMVD_IRQ_TIMER_C = 4'h5,
      MMVD_IRQ_CAPTURE = 4'h6,
      MMVD_IRQ_KEY = 4'h7,
      MMVD_IRQ_SER_RX = 4'h8,
      MMVD_IRQ_SER_TX = 4'h9
   } mmvd_irq_e;

   localparam logic [3:0] IRQ_LAST = 4'h9;

   typedef enum logic [2:0] {
      MMVD_RG_NONE = 3'h0,
      MMVD_RG_VECTOR = 3'h1,
      MMVD_RG_TBL_CALL = 3'h2,
      MMVD_RG_ROM = 3'h3,
      MMVD_RG_LS_RAM = 3'h4,
      MMVD_RG_HS_RAM = 3'h5,
      MMVD_RG_SFR = 3'h6
   } mmvd_region_e;

   typedef enum logic [1:0] {
      MMVD_ST_WAIT_LO = 2'h0,
      MMVD_ST_WAIT_HI = 2'h1,
      MMVD_ST_CAP_HI = 2'h2,
      MMVD_ST_RUN = 2'h3
   } mmvd_state_e;

   function automatic logic [15:0] mmvd_vec_addr(input logic [3:0] src);
      case (src)
         4'h0: mmvd_vec_addr = VEC_WDT;
         4'h1: mmvd_vec_addr = VEC_EXT0;
         4'h2: mmvd_vec_addr = VEC_EXT1;
         4'h3: mmvd_vec_addr = VEC_TMR_A;
         4'h4: mmvd_vec_addr = VEC_TMR_B;
         4'h5: mmvd_vec_addr = VEC_TMR_C;
         4'h6: mmvd_vec_addr = VEC_CAPT;
         4'h7: mmvd_vec_addr = VEC_KEY;
         4'h8: mmvd_vec_addr = VEC_SER_RX;
         4'h9: mmvd_vec_addr = VEC_SER_TX;
         default: mmvd_vec_addr = VEC_RESET;
      endcase
   endfunction

endpackage

// ==== mmvd_dec_if.sv ====
`timescale 1ns/1ps
interface mmvd_dec_if;
   logic [15:0] addr;
   logic stack_acc;
   mmvd_pkg::mmvd_region_e region;
   logic [15:0] offset;
   logic short_area;
   logic stack_bad;

   modport dec (input addr, input stack_acc, output region, output offset, output short_area, output stack_bad);
   modport user (output addr, output stack_acc, input region, input offset, input short_area, input stack_bad);
endinterface

// ==== mmvd_region_dec.sv ====
`timescale 1ns/1ps
module mmvd_region_dec #(
   parameter int unsigned ROM_SIZE = mmvd_pkg::ROM_LARGE,
   parameter int unsigned HS_SIZE = mmvd_pkg::HS_LARGE,
   parameter int unsigned LS_SIZE = mmvd_pkg::LS_LARGE,
   parameter logic [15:0] LS_BASE = mmvd_pkg::LS_RAM_BASE_DEF
) (
   mmvd_dec_if.dec d
);
   localparam logic [16:0] HS_BASE = 17'(32'(mmvd_pkg::HS_RAM_LAST) + 32'd1 - HS_SIZE);
   localparam logic [16:0] LS_END = 17'(32'(LS_BASE) + LS_SIZE);
   localparam logic [16:0] ROM_END = 17'(ROM_SIZE);

   always_comb begin
      d.region = mmvd_pkg::MMVD_RG_NONE;
      d.offset = 16'h0000;
      if (d.addr >= mmvd_pkg::SFR_BASE) begin
         d.region = mmvd_pkg::MMVD_RG_SFR;
         d.offset = d.addr - mmvd_pkg::SFR_BASE;
      end else if ({1'b0, d.addr} >= HS_BASE) begin
         d.region = mmvd_pkg::MMVD_RG_HS_RAM;
         d.offset = 16'({1'b0, d.addr} - HS_BASE);
      end else if ({1'b0, d.addr} >= {1'b0, LS_BASE} && {1'b0, d.addr} < LS_END) begin
         d.region = mmvd_pkg::MMVD_RG_LS_RAM;
         d.offset = d.addr - LS_BASE;
      end else if (d.addr <= mmvd_pkg::VEC_LAST) begin
         d.region = mmvd_pkg::MMVD_RG_VECTOR;
         d.offset = d.addr;
      end else if (d.addr >= mmvd_pkg::TBL_CALL_BASE && d.addr <= mmvd_pkg::TBL_CALL_LAST) begin
         d.region = mmvd_pkg::MMVD_RG_TBL_CALL;
         d.offset = d.addr - mmvd_pkg::TBL_CALL_BASE;
      end else if ({1'b0, d.addr} < ROM_END) begin
         d.region = mmvd_pkg::MMVD_RG_ROM;
         d.offset = d.addr;
      end
   end

   assign d.short_area = (d.addr >= mmvd_pkg::DATA_AREA_BASE);
   // Stack is only legal in high-speed RAM
   assign d.stack_bad = d.stack_acc && (d.region != mmvd_pkg::MMVD_RG_HS_RAM);
endmodule

// ==== mmvd_decode_chk.sv ====
`timescale 1ns/1ps
module mmvd_decode_chk (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic reset_pin_n,
   // Program flow
   input wire logic irq_req,
   input wire logic [3:0] irq_src,
   input wire logic one_byte_table_call,
   input wire logic branch_req,
   input wire logic fetch_req,
   input wire logic [15:0] program_counter,
   input wire logic pc_valid,
   input wire logic busy,
   input wire logic fetch_valid,
   // Data decode
   input wire logic data_req,
   input wire logic [15:0] data_addr,
   input wire logic data_stack,
   input wire logic dec_valid,
   input wire logic [2:0] dec_region,
   input wire logic [15:0] dec_offset,
   input wire logic dec_short_area,
   input wire logic dec_stack_fault
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst || !reset_pin_n);

   sequence fetch_go;
      fetch_req && !busy && !irq_req && !one_byte_table_call && !branch_req;
   endsequence
   // An interrupt or table call in the cycle after a fetch request cancels it; a branch does not
   sequence calm;
      !irq_req && !one_byte_table_call && !branch_req;
   endsequence
   sequence vec_go;
      (irq_req && irq_src <= 4'h9 || one_byte_table_call) && !busy;
   endsequence

   a_fetch_latency: assert property (fetch_go ##1 calm [*2] |=> fetch_valid)
      else $error("fetch result missing three cycles after request");
   a_vector_load: assert property (vec_go |=> busy && !pc_valid ##3 pc_valid && !busy)
      else $error("vector load timing wrong");
   a_reset_pin: assert property (disable iff (srst) !reset_pin_n |=> busy && !pc_valid && program_counter == 16'h0000)
      else $error("low reset pin did not reset the counter");
   a_dec_answer: assert property (data_req |=> dec_valid)
      else $error("decode answer missing");
   a_dec_quiet: assert property (!data_req |=> !dec_valid)
      else $error("decode answer without request");
   a_sfr_window: assert property (data_req && data_addr >= 16'hff00 |=> dec_region == 3'h6 && dec_offset == {8'h00, $past(data_addr[7:0])})
      else $error("peripheral window decode wrong");
   a_short_area: assert property (data_req |=> dec_short_area == ($past(data_addr) >= 16'hfe00))
      else $error("short area flag wrong");
   a_vec_region: assert property (data_req && data_addr <= 16'h0019 |=> dec_region == 3'h1)
      else $error("vector area decode wrong");
   a_table_region: assert property (data_req && data_addr >= 16'h0040 && data_addr <= 16'h007f |=> dec_region == 3'h2 && dec_offset == $past(data_addr) - 16'h0040)
      else $error("table call area decode wrong");
   a_stack_flag: assert property (data_req |=> dec_stack_fault == ($past(data_stack) && dec_region != 3'h5))
      else $error("stack flag wrong");
endmodule

bind mmvd_decode mmvd_decode_chk u_chk (.*);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic reset_pin_n = 1'b1;
   logic irq_req = 1'b0;
   logic [3:0] irq_src = 4'h0;
   logic one_byte_table_call = 1'b0;
   logic [4:0] table_index = 5'h00;
   logic branch_req = 1'b0;
   logic [15:0] branch_addr = 16'h0000;
   logic fetch_req = 1'b0;
   logic [7:0] rom_rdata = 8'h00;
   logic data_req = 1'b0;
   logic [15:0] data_addr = 16'h0000;
   logic data_stack = 1'b0;
   logic [15:0] rom_addr, program_counter, dec_offset;
   logic pc_valid, busy, fetch_valid, fetch_fault, dec_valid, dec_short_area, dec_stack_fault;
   logic [7:0] fetch_byte;
   logic [2:0] dec_region;
   logic s_dec_valid;
   logic [2:0] s_dec_region;
   logic [15:0] s_dec_offset;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   // Address, offset, region
   localparam logic [47:0] DCASE [17] = '{48'hff10_0010_0006, 48'hffff_00ff_0006, 48'hfe00_0040_0005,
      48'hfdc0_0000_0005, 48'hfeff_013f_0005, 48'hfdbf_0000_0000, 48'hf800_0000_0004, 48'hf8ff_00ff_0004,
      48'hf900_0000_0000, 48'h0000_0000_0001, 48'h0019_0019_0001, 48'h001a_001a_0003, 48'h0040_0000_0002,
      48'h007f_003f_0002, 48'h0080_0080_0003, 48'h7fff_7fff_0003, 48'h8000_0000_0000};
   // Small variant: address, offset, region
   localparam logic [47:0] SCASE [6] = '{48'hfdff_0000_0000, 48'hfe00_0000_0005, 48'hf87f_007f_0004,
      48'hf880_0000_0000, 48'h3fff_3fff_0003, 48'h4000_0000_0000};

   mmvd_decode DUT (.*);

   // Small variant shares every input; only its data decode is judged
   mmvd_decode #(
      .LARGE_VARIANT(1'b0)
   ) DUT_small (
      .clk_sys(clk_sys),
      .srst(srst),
      .reset_pin_n(reset_pin_n),
      .irq_req(irq_req),
      .irq_src(irq_src),
      .one_byte_table_call(one_byte_table_call),
      .table_index(table_index),
      .branch_req(branch_req),
      .branch_addr(branch_addr),
      .fetch_req(fetch_req),
      .rom_addr(),
      .rom_rdata(rom_rdata),
      .program_counter(),
      .pc_valid(),
      .busy(),
      .fetch_byte(),
      .fetch_valid(),
      .fetch_fault(),
      .data_req(data_req),
      .data_addr(data_addr),
      .data_stack(data_stack),
      .dec_valid(s_dec_valid),
      .dec_region(s_dec_region),
      .dec_offset(s_dec_offset),
      .dec_short_area(),
      .dec_stack_fault()
   );

   always #12.5 clk_sys = ~clk_sys;

   function automatic logic [7:0] rom(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5c;
   endfunction

   // Synchronous ROM, one cycle behind the address
   always @(posedge clk_sys) begin
      rom_rdata <= rom(rom_addr);
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_b(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic settle(input logic [15:0] va);
      int n;
      n = 0;
      repeat (2) @(negedge clk_sys);
      while (busy !== 1'b0 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      chk_b("pc_valid", 1'b1, pc_valid);
      chk_w("program_counter", {rom(va + 16'h0001), rom(va)}, program_counter);
      chk_w("rom_addr_after_vector", {rom(va + 16'h0001), rom(va)}, rom_addr);
   endtask

   task automatic boot(input logic pin);
      srst = !pin;
      reset_pin_n = !pin;
      repeat (3) @(negedge clk_sys);
      chk_b("busy_in_reset", 1'b1, busy);
      srst = 1'b0;
      reset_pin_n = 1'b1;
      settle(16'h0000);
   endtask

   task automatic vec(input logic irq, input logic [3:0] src, input logic [4:0] idx, input logic [15:0] va);
      irq_req = irq;
      irq_src = src;
      one_byte_table_call = !irq || src > 4'h9;
      table_index = idx;
      @(negedge clk_sys);
      irq_req = 1'b0;
      one_byte_table_call = 1'b0;
      settle(va);
   endtask

   task automatic fetch(input logic [15:0] a, input logic fault);
      int n;
      n = 0;
      branch_req = 1'b1;
      branch_addr = a;
      @(negedge clk_sys);
      branch_req = 1'b0;
      fetch_req = 1'b1;
      @(negedge clk_sys);
      fetch_req = 1'b0;
      chk_w("rom_addr", a, rom_addr);
      while (fetch_valid !== 1'b1 && n < 5) begin
         @(negedge clk_sys);
         n++;
      end
      chk_b("fetch_valid", 1'b1, fetch_valid);
      chk_w("fetch_byte", {8'h00, rom(a)}, {8'h00, fetch_byte});
      chk_b("fetch_fault", fault, fetch_fault);
      chk_w("pc_after_fetch", a + 16'h0001, program_counter);
   endtask

   task automatic decode_map();
      logic [15:0] a, r;
      for (int i = 0; i < 17; i++) begin
         a = DCASE[i][47:32];
         r = DCASE[i][15:0];
         data_req = 1'b1;
         data_addr = a;
         data_stack = i[0];
         @(negedge clk_sys);
         chk_b("dec_valid", 1'b1, dec_valid);
         chk_w("dec_region", r, {13'h0000, dec_region});
         chk_w("dec_offset", DCASE[i][31:16], dec_offset);
         chk_b("dec_short_area", a >= 16'hfe00, dec_short_area);
         chk_b("dec_stack_fault", i[0] && r != 16'h0005, dec_stack_fault);
      end
      for (int i = 0; i < 6; i++) begin
         data_req = 1'b1;
         data_addr = SCASE[i][47:32];
         data_stack = 1'b0;
         @(negedge clk_sys);
         chk_b("small_dec_valid", 1'b1, s_dec_valid);
         chk_w("small_dec_region", SCASE[i][15:0], {13'h0000, s_dec_region});
         chk_w("small_dec_offset", SCASE[i][31:16], s_dec_offset);
      end
      data_req = 1'b0;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      boot(1'b0);
      for (int s = 0; s < 10; s++) begin
         vec(1'b1, 4'(s), 5'h00, 16'(4 + 2 * s));
      end
      vec(1'b0, 4'h0, 5'h00, 16'h0040);
      vec(1'b0, 4'h0, 5'h1f, 16'h007e);
      vec(1'b1, 4'ha, 5'h02, 16'h0044);
      fetch(16'h1234, 1'b0);
      fetch(16'h7fff, 1'b0);
      fetch(16'h8000, 1'b1);
      decode_map();
      boot(1'b1);
      summarize();
   end
endmodule
